// ---- shared/ufb_consts.svh ----
// constants for the fractional baud generator and transmitter core
`ifndef UFB_CONSTS_SVH
`define UFB_CONSTS_SVH
`define UFB_ADDR_THR 4'h0
`define UFB_ADDR_LCR 4'h3
`define UFB_ADDR_MCR 4'h4
`define UFB_ADDR_LSR 4'h5
`define UFB_ADDR_DLL 4'h8
`define UFB_ADDR_DLM 4'h9
`define UFB_ADDR_DLD 4'hA
`define UFB_DLL_RST 8'h01
`define UFB_DLM_RST 8'h00
`define UFB_DLD_RST 8'h00
`define UFB_MCR_PRESCALE 7
`define UFB_PRESCALE_LAST 2'h3
`define UFB_DLD_FRAC 3:0
`define UFB_DLD_MODE 5:4
`define UFB_LCR_WLEN 1:0
`define UFB_LCR_STOP2 2
`define UFB_LCR_PAREN 3
`define UFB_LCR_EVEN 4
`define UFB_WLEN_BASE 3'h4
`define UFB_LSR_THRE 5
`define UFB_LSR_TEMT 6
`define UFB_FIFO_DEPTH 7'h40
`define UFB_TPB16_LAST 4'hF
`define UFB_TPB8_LAST 4'h7
`define UFB_TPB4_LAST 4'h3
`define UFB_DIV_ZERO 17'h10000
`endif

// ---- shared/ufb_pkg.sv ----
// types for the fractional baud generator and transmitter core
package ufb_pkg;
   typedef enum logic [1:0] {
      UFB_M16 = 2'b00,
      UFB_M8 = 2'b01,
      UFB_M4 = 2'b10,
      UFB_MRSV = 2'b11
   } ufb_mode_e;
   typedef enum logic [2:0] {
      UFB_IDLE = 3'b000,
      UFB_START = 3'b001,
      UFB_DATA = 3'b010,
      UFB_PAR = 3'b011,
      UFB_STOP = 3'b100
   } ufb_tx_state_e;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } ufb_reg_req_s;
   typedef struct packed {
      logic [7:0] dll;
      logic [7:0] baud_divisor_high_byte;
      logic [7:0] baud_divisor_fraction_and_sampling;
      logic [7:0] modem_control_reg;
      logic [7:0] lcr;
      logic [1:0] pre_cnt;
      logic [15:0] act_div;
      logic [3:0] act_frac;
      logic [1:0] act_mode;
      logic [16:0] div_cnt;
      logic [3:0] acc;
      logic tick;
      logic [5:0] wr_ptr;
      logic [5:0] rd_ptr;
      logic [6:0] count;
      logic [7:0] tx_shift_reg;
      ufb_tx_state_e st;
      logic [2:0] bit_cnt;
      logic [3:0] tick_cnt;
      logic parity;
      logic tx;
      logic [7:0] rdata;
   } ufb_state_s;
endpackage

// ---- core/ufb_core.sv ----
// fractional baud generator, transmit queue and transmit shifter of one channel
`timescale 1ns/10ps
`include "ufb_consts.svh"

module ufb_core
   import ufb_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire ufb_reg_req_s reg_req_i,
   output logic [7:0] reg_rdata_o,
   output logic tx_o,
   output logic sample_tick_o
);
   ufb_state_s q;
   ufb_state_s d;
   logic [7:0] fifo_mem [0:63];
   logic pe;
   logic push;
   logic pop;
   logic start_char;
   logic bit_end;
   logic [3:0] tpb_last;
   logic [4:0] sum;
   logic [7:0] line_status_reg;
   logic [3:0] start_ticks;

   function automatic logic [3:0] bit_last(input ufb_mode_e m);
      unique case (m)
         UFB_M8: bit_last = `UFB_TPB8_LAST;
         UFB_M4: bit_last = `UFB_TPB4_LAST;
         default: bit_last = `UFB_TPB16_LAST;
      endcase
   endfunction

   function automatic logic [16:0] div_eff(input logic [15:0] v);
      div_eff = (v == 16'h0000) ? `UFB_DIV_ZERO : {1'b0, v};
   endfunction

   always_comb begin
      d = q;
      d.tick = 1'b0;
      pop = 1'b0;
      start_char = 1'b0;
      sum = 5'h00;
      line_status_reg = 8'h00;
      line_status_reg[`UFB_LSR_THRE] = (q.count == 7'h00);
      line_status_reg[`UFB_LSR_TEMT] = (q.count == 7'h00) && (q.st == UFB_IDLE);
      push = reg_req_i.wr && (reg_req_i.addr == `UFB_ADDR_THR) &&
             (q.count != `UFB_FIFO_DEPTH);
      // host port writes
      if (reg_req_i.wr) begin
         case (reg_req_i.addr)
            `UFB_ADDR_LCR: d.lcr = reg_req_i.wdata;
            `UFB_ADDR_MCR: d.modem_control_reg = reg_req_i.wdata;
            `UFB_ADDR_DLL: d.dll = reg_req_i.wdata;
            `UFB_ADDR_DLM: d.baud_divisor_high_byte = reg_req_i.wdata;
            `UFB_ADDR_DLD: d.baud_divisor_fraction_and_sampling = reg_req_i.wdata;
            default: ;
         endcase
      end
      if (reg_req_i.rd) begin
         case (reg_req_i.addr)
            `UFB_ADDR_LCR: d.rdata = q.lcr;
            `UFB_ADDR_MCR: d.rdata = q.modem_control_reg;
            `UFB_ADDR_LSR: d.rdata = line_status_reg;
            `UFB_ADDR_DLL: d.rdata = q.dll;
            `UFB_ADDR_DLM: d.rdata = q.baud_divisor_high_byte;
            `UFB_ADDR_DLD: d.rdata = q.baud_divisor_fraction_and_sampling;
            default: d.rdata = 8'h00;
         endcase
      end
      // prescaler is a strobe, so the generator never sees another clock
      d.pre_cnt = q.pre_cnt + 2'h1;
      pe = q.modem_control_reg[`UFB_MCR_PRESCALE] ? (q.pre_cnt == `UFB_PRESCALE_LAST) : 1'b1;
      if (pe) begin
         if (q.div_cnt == 17'h00000) begin
            d.tick = 1'b1;
            // shadow copies change only here, so no tick is cut short
            d.act_div = {q.baud_divisor_high_byte, q.dll};
            d.act_frac = q.baud_divisor_fraction_and_sampling[`UFB_DLD_FRAC];
            d.act_mode = q.baud_divisor_fraction_and_sampling[`UFB_DLD_MODE];
            // carry stretches this period by one prescaled clock
            sum = {1'b0, q.acc} + {1'b0, q.baud_divisor_fraction_and_sampling[`UFB_DLD_FRAC]};
            d.acc = sum[3:0];
            d.div_cnt = div_eff({q.baud_divisor_high_byte, q.dll}) - 17'h00001 + {16'h0000, sum[4]};
         end else begin
            d.div_cnt = q.div_cnt - 17'h00001;
         end
      end
      // transmitter
      tpb_last = bit_last(ufb_mode_e'(q.act_mode));
      bit_end = q.tick && (q.tick_cnt == tpb_last);
      if (q.tick && (q.st != UFB_IDLE)) begin
         d.tick_cnt = bit_end ? 4'h0 : q.tick_cnt + 4'h1;
      end
      unique case (q.st)
         UFB_IDLE: begin
            d.tx = 1'b1;
            start_char = q.tick && (q.count != 7'h00);
         end
         UFB_START: begin
            if (bit_end) begin
               d.st = UFB_DATA;
               d.tx = q.tx_shift_reg[0];
               d.parity = q.parity ^ q.tx_shift_reg[0];
               d.tx_shift_reg = {1'b0, q.tx_shift_reg[7:1]};
               d.bit_cnt = 3'h0;
            end
         end
         UFB_DATA: begin
            if (bit_end) begin
               if (q.bit_cnt == ({1'b0, q.lcr[`UFB_LCR_WLEN]} + `UFB_WLEN_BASE)) begin
                  d.bit_cnt = 3'h0;
                  if (q.lcr[`UFB_LCR_PAREN]) begin
                     d.st = UFB_PAR;
                     d.tx = q.parity;
                  end else begin
                     d.st = UFB_STOP;
                     d.tx = 1'b1;
                  end
               end else begin
                  d.bit_cnt = q.bit_cnt + 3'h1;
                  d.tx = q.tx_shift_reg[0];
                  d.parity = q.parity ^ q.tx_shift_reg[0];
                  d.tx_shift_reg = {1'b0, q.tx_shift_reg[7:1]};
               end
            end
         end
         UFB_PAR: begin
            if (bit_end) begin
               d.st = UFB_STOP;
               d.tx = 1'b1;
               d.bit_cnt = 3'h0;
            end
         end
         UFB_STOP: begin
            if (bit_end) begin
               if (q.bit_cnt == {2'b00, q.lcr[`UFB_LCR_STOP2]}) begin
                  d.st = UFB_IDLE;
                  start_char = q.count != 7'h00;
               end else begin
                  d.bit_cnt = q.bit_cnt + 3'h1;
               end
            end
         end
         default: d.st = UFB_IDLE;
      endcase
      // back-to-back characters leave no idle gap after the stop bit
      if (start_char) begin
         d.st = UFB_START;
         d.tx = 1'b0;
         d.tx_shift_reg = fifo_mem[q.rd_ptr];
         d.rd_ptr = q.rd_ptr + 6'h01;
         d.tick_cnt = 4'h0;
         d.parity = ~q.lcr[`UFB_LCR_EVEN];
         pop = 1'b1;
      end
      d.wr_ptr = q.wr_ptr + {5'h00, push};
      d.count = q.count + {6'h00, push} - {6'h00, pop};
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
         q.dll <= `UFB_DLL_RST;
         q.baud_divisor_high_byte <= `UFB_DLM_RST;
         q.baud_divisor_fraction_and_sampling <= `UFB_DLD_RST;
         q.tx <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // queue storage needs no reset; pointers guard it
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         fifo_mem[q.wr_ptr] <= reg_req_i.wdata;
      end
   end

   assign reg_rdata_o = q.rdata;
   assign tx_o = q.tx;
   assign sample_tick_o = q.tick;

   // helper: ticks spent in the start bit
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         start_ticks <= 4'h0;
      end else if (q.st != UFB_START) begin
         start_ticks <= 4'h0;
      end else if (q.tick) begin
         start_ticks <= start_ticks + 4'h1;
      end
   end

   a_div_reset_val: assert property (@(posedge sys_clk_i)
      rst_i |-> (q.dll == 8'h01 && q.baud_divisor_high_byte == 8'h00 && q.baud_divisor_fraction_and_sampling == 8'h00))
      else $error("divisor reset value wrong");
   // prescale must have been on long enough that the last ticks were also prescaled
   a_prescale_gap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (q.tick && q.modem_control_reg[`UFB_MCR_PRESCALE] && $past(q.modem_control_reg[`UFB_MCR_PRESCALE])
       && $past(q.modem_control_reg[`UFB_MCR_PRESCALE], 2) && $past(q.modem_control_reg[`UFB_MCR_PRESCALE], 3))
      |-> !$past(q.tick, 1) && !$past(q.tick, 2))
      else $error("prescaled tick too close");
   a_div_tick_gap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (q.tick && q.act_div > 16'h0001 && !q.modem_control_reg[7]) |=> !q.tick)
      else $error("tick period below divisor");
   a_frac_acc: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      q.tick |-> q.acc == 4'($past(q.acc) + q.act_frac))
      else $error("fraction accumulator wrong");
   a_shadow_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !q.tick |-> $stable(q.act_div) && $stable(q.act_mode) && $stable(q.act_frac))
      else $error("divisor changed mid period");
   a_start_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (q.st == UFB_START) |-> !tx_o)
      else $error("start bit not low");
   a_lsb_first: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ($past(q.st) == UFB_START && q.st == UFB_DATA) |-> tx_o == $past(q.tx_shift_reg[0]))
      else $error("first data bit not lsb");
   a_bit_length: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      ($past(q.st) == UFB_START && q.st == UFB_DATA && $stable(q.act_mode))
      |-> start_ticks == 4'(tpb_last + 4'h1))
      else $error("start bit length wrong");
   a_status_bits: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (reg_req_i.rd && reg_req_i.addr == `UFB_ADDR_LSR) |=>
      (reg_rdata_o[`UFB_LSR_TEMT] == ($past(q.count) == 7'h00 && $past(q.st) == UFB_IDLE)
       && reg_rdata_o[`UFB_LSR_THRE] == ($past(q.count) == 7'h00)))
      else $error("line status bits wrong");
   a_queue_bound: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      q.count <= 7'h40)
      else $error("queue overfilled");

   c_frac_carry: cover property (@(posedge sys_clk_i) disable iff (rst_i)
      q.tick && sum[4]);
   c_char_done: cover property (@(posedge sys_clk_i) disable iff (rst_i)
      q.st == UFB_STOP ##1 q.st == UFB_IDLE);
   c_queue_full: cover property (@(posedge sys_clk_i) disable iff (rst_i)
      q.count == 7'h40);
   c_mode_4x: cover property (@(posedge sys_clk_i) disable iff (rst_i)
      q.tick && q.act_mode == 2'b10 && q.st == UFB_DATA);
endmodule

// ---- bench/ufb_rx_model.sv ----
// remote serial receiver that samples the transmit line mid-bit
`timescale 1ns/10ps
module ufb_rx_model (
   input wire logic sys_clk_i,
   input wire logic line_i,
   input wire logic [7:0] bit_clks_i,
   input wire logic [3:0] nbits_i,
   input wire logic par_en_i,
   output logic [7:0] data_o,
   output logic par_o,
   output logic [15:0] start_len_o,
   output int frames_o
);
   int c;
   int b;
   int n;
   int len;
   int slot;
   logic [7:0] sh;
   initial begin
      data_o = 8'h00;
      par_o = 1'b0;
      start_len_o = 16'h0000;
      frames_o = 0;
      forever begin
         @(negedge line_i);
         b = int'(bit_clks_i);
         n = int'(nbits_i);
         c = 0;
         len = 0;
         sh = 8'h00;
         // stop at the middle of the first stop bit; the next fall is a new start
         while (c < b * (n + 1 + int'(par_en_i)) + b / 2) begin
            @(posedge sys_clk_i);
            #1;
            c++;
            if (line_i === 1'b1 && len == 0) begin
               len = c;
            end
            slot = c / b - 1;
            if (c % b == b / 2 && c > b) begin
               if (slot < n) begin
                  sh[slot] = line_i;
               end else if (slot == n && par_en_i) begin
                  par_o = line_i;
               end
            end
         end
         data_o = sh;
         start_len_o = 16'(len);
         frames_o++;
      end
   end
endmodule

// ---- bench/testbench.sv ----
// register-level bench: divisor timing, sampling modes and transmit frames
`timescale 1ns/10ps
`include "ufb_consts.svh"
module testbench;
   import ufb_pkg::*;
   logic sys_clk_i;
   logic rst_i;
   ufb_reg_req_s req;
   logic [7:0] rdata;
   logic [7:0] bclk;
   logic [7:0] rx_data;
   logic tx;
   logic tick;
   logic rx_par;
   logic [3:0] nbits;
   logic par_en;
   logic [15:0] slen;
   int frames;
   int bad_count;
   int compares;
   int g;
   ufb_core dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_req_i(req),
      .reg_rdata_o(rdata), .tx_o(tx), .sample_tick_o(tick));
   ufb_rx_model rx_u (.sys_clk_i(sys_clk_i), .line_i(tx), .bit_clks_i(bclk),
      .nbits_i(nbits), .par_en_i(par_en), .data_o(rx_data), .par_o(rx_par),
      .start_len_o(slen), .frames_o(frames));
   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   task automatic results();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge sys_clk_i);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge sys_clk_i);
      req.wr = 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
      @(negedge sys_clk_i);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge sys_clk_i);
      req.rd = 1'b0;
      @(negedge sys_clk_i);
      chk(nm, {8'h00, rdata}, {8'h00, e});
   endtask
   // sum of n tick-to-tick spacings, counted in clocks
   task automatic gaps(input int n, output int tot);
      int k;
      tot = 0;
      k = 0;
      while (tick !== 1'b1 && k < 70000) begin
         @(negedge sys_clk_i);
         k++;
      end
      if (k >= 70000) begin
         bad_count++;
         results();
      end
      for (int i = 0; i < n; i++) begin
         k = 0;
         do begin
            @(negedge sys_clk_i);
            k++;
         end while (tick !== 1'b1 && k < 70000);
         tot += k;
      end
      if (k >= 70000) begin
         bad_count++;
         results();
      end
   endtask
   task automatic wait_frames(input int n);
      int k;
      k = 0;
      while (frames < n && k < 20000) begin
         @(negedge sys_clk_i);
         k++;
      end
      if (k >= 20000) begin
         bad_count++;
         results();
      end
   endtask
   initial begin
      req = '0;
      rst_i = 1'b1;
      bclk = 8'h10;
      nbits = 4'h8;
      par_en = 1'b0;
      bad_count = 0;
      compares = 0;
      repeat (5) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      rst_i = 1'b0;
      rchk("dll", `UFB_ADDR_DLL, 8'h01);
      rchk("dlm", `UFB_ADDR_DLM, 8'h00);
      rchk("dld", `UFB_ADDR_DLD, 8'h00);
      rchk("lsr idle", `UFB_ADDR_LSR, 8'h60);
      rchk("unmapped", 4'hF, 8'h00);
      gaps(4, g);
      chk("div one", 16'(g), 16'h0004);
      wr(`UFB_ADDR_DLL, 8'h03);
      gaps(2, g);
      gaps(2, g);
      chk("div three", 16'(g), 16'h0006);
      wr(`UFB_ADDR_MCR, 8'h80);
      rchk("mcr", `UFB_ADDR_MCR, 8'h80);
      gaps(2, g);
      gaps(2, g);
      chk("prescale", 16'(g), 16'h0018);
      wr(`UFB_ADDR_MCR, 8'h00);
      wr(`UFB_ADDR_DLL, 8'h02);
      wr(`UFB_ADDR_DLD, 8'h08);
      gaps(2, g);
      gaps(16, g);
      chk("fraction", 16'(g), 16'h0028);
      wr(`UFB_ADDR_DLD, 8'h00);
      // byte order keeps a zero divisor (65536) from ever going live
      wr(`UFB_ADDR_DLM, 8'h01);
      wr(`UFB_ADDR_DLL, 8'h00);
      gaps(2, g);
      gaps(1, g);
      chk("high byte", 16'(g), 16'h0100);
      wr(`UFB_ADDR_DLL, 8'h01);
      wr(`UFB_ADDR_DLM, 8'h00);
      wr(`UFB_ADDR_LCR, 8'h03);
      // both bytes have bit 0 set so the start bit length is measurable
      for (int m = 0; m < 3; m++) begin
         wr(`UFB_ADDR_DLD, {2'b00, 2'(m), 4'h0});
         bclk = 8'h10 >> m;
         wr(`UFB_ADDR_THR, 8'hA5);
         wr(`UFB_ADDR_THR, 8'h3B);
         rchk("lsr busy", `UFB_ADDR_LSR, 8'h00);
         wait_frames(2 * m + 1);
         chk("first byte", {8'h00, rx_data}, 16'h00A5);
         chk("bit time", slen, {8'h00, bclk});
         wait_frames(2 * m + 2);
         chk("second byte", {8'h00, rx_data}, 16'h003B);
         // model reports mid stop bit, so the shifter is still busy
         rchk("lsr shifting", `UFB_ADDR_LSR, 8'h20);
         repeat (int'(bclk)) @(negedge sys_clk_i);
         rchk("lsr drained", `UFB_ADDR_LSR, 8'h60);
      end
      nbits = 4'h7;
      par_en = 1'b1;
      for (int e = 0; e < 2; e++) begin
         wr(`UFB_ADDR_LCR, {3'b000, 1'(e), 4'hA});
         wr(`UFB_ADDR_THR, 8'h35);
         wait_frames(7 + e);
         chk("short word", {8'h00, rx_data}, 16'h0035);
         chk("parity", {15'h0000, rx_par}, {15'h0000, ~1'(e)});
      end
      results();
   end
endmodule
